// *** dv/dtc_core_model.sv ***
module dtc_core_model (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Requests in, vector pulses out
    input wire logic [3:0] irq,
    output logic [3:0] ack
);
    // Masking with the pulse itself keeps a flag that clears one edge
    // later from being vectored twice.
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            ack <= 4'h0;
        else
            ack <= irq & ~ack;
    end
endmodule : dtc_core_model

// *** dv/dual_timer_counter_control_bench.sv ***
module dual_timer_counter_control_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout;
    logic [31:0] hrdata;
    logic pin0_n = 1'b1;
    logic pin1_n = 1'b1;
    logic cnt_pin0 = 1'b1;
    logic [3:0] irq;
    logic [3:0] ack;
    logic [7:0] rd;
    int num_errors = 0;
    int num_checks = 0;
    int cyc = 0;

    dtc_timer_ctrl uut (.sys_clk(sys_clk), .nrst(nrst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(), .hrdata(hrdata), .ext_irq_pin0_n(pin0_n),
        .ext_irq_pin1_n(pin1_n), .count_input_pin0(cnt_pin0),
        .count_input_pin1(1'b1), .vec_ack_tmr0(ack[0]),
        .vec_ack_tmr1(ack[1]), .vec_ack_ext0(ack[2]),
        .vec_ack_ext1(ack[3]), .irq_req_tmr0(irq[0]),
        .irq_req_tmr1(irq[1]), .irq_req_ext0(irq[2]),
        .irq_req_ext1(irq[3]));
    dtc_core_model core (.sys_clk(sys_clk), .nrst(nrst), .irq(irq),
        .ack(ack));

    initial
    begin
        forever #20 sys_clk = ~sys_clk;
    end

    task automatic finish_test();
        if (num_errors == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : finish_test

    // Ready and read data are taken at the rising edge itself, so the
    // next change of the request lands just after that edge.
    task automatic wait_rdy();
        @(posedge sys_clk);
        while (hreadyout !== 1'b1)
            @(posedge sys_clk);
        rd = hrdata[7:0];
    endtask : wait_rdy

    task automatic bus(input bit wr, input logic [11:0] a,
                       input logic [7:0] d);
        @(posedge sys_clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {20'h0, a};
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        wait_rdy();
    endtask : bus

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            num_errors++;
        end
    endtask : chk

    task automatic rchk(input logic [11:0] a, input logic [7:0] exp);
        bus(1'b0, a, 8'h00);
        chk(rd, exp);
    endtask : rchk

    task automatic wait_irq(input int i, input logic v);
        int n;
        n = 0;
        while (irq[i] !== v && n < 200)
        begin
            @(posedge sys_clk);
            n++;
        end
        chk({7'h0, irq[i]}, {7'h0, v});
    endtask : wait_irq

    task automatic pulse(input int k);
        repeat (k)
        begin
            cnt_pin0 <= 1'b0;
            repeat (3) @(posedge sys_clk);
            cnt_pin0 <= 1'b1;
            repeat (3) @(posedge sys_clk);
        end
    endtask : pulse

    task automatic t_reset();
        rchk(dtc_pkg::ADDR_TCS, 8'h00);
        rchk(dtc_pkg::ADDR_TMC, 8'h00);
        rchk(12'hFF0, 8'h00);
    endtask : t_reset

    task automatic t_mode16();
        bus(1'b1, dtc_pkg::ADDR_CNT0_LO, 8'hFF);
        bus(1'b1, dtc_pkg::ADDR_CNT0_HI, 8'hFF);
        bus(1'b1, dtc_pkg::ADDR_TMC, 8'h01);
        bus(1'b1, dtc_pkg::ADDR_IRQ_EN, 8'h02);
        bus(1'b1, dtc_pkg::ADDR_TCS, 8'h10);
        repeat (30) @(posedge sys_clk);
        chk({7'h0, irq[0]}, 8'h00);
        rchk(dtc_pkg::ADDR_CNT0_HI, 8'h00);
        rchk(dtc_pkg::ADDR_TCS, 8'h30);
        bus(1'b1, dtc_pkg::ADDR_IRQ_EN, 8'h82);
        wait_irq(0, 1'b1);
        wait_irq(0, 1'b0);
        rchk(dtc_pkg::ADDR_TCS, 8'h10);
        bus(1'b1, dtc_pkg::ADDR_TCS, 8'h00);
    endtask : t_mode16

    task automatic t_reload();
        bus(1'b1, dtc_pkg::ADDR_CNT1_LO, 8'hFE);
        bus(1'b1, dtc_pkg::ADDR_CNT1_HI, 8'h80);
        bus(1'b1, dtc_pkg::ADDR_TMC, 8'h20);
        bus(1'b1, dtc_pkg::ADDR_IRQ_EN, 8'h88);
        bus(1'b1, dtc_pkg::ADDR_TCS, 8'h40);
        wait_irq(1, 1'b1);
        rchk(dtc_pkg::ADDR_CNT1_LO, 8'h80);
        rchk(dtc_pkg::ADDR_CNT1_HI, 8'h80);
        bus(1'b1, dtc_pkg::ADDR_TCS, 8'h00);
    endtask : t_reload

    task automatic t_mode13();
        bus(1'b1, dtc_pkg::ADDR_TMC, 8'h00);
        bus(1'b1, dtc_pkg::ADDR_CNT0_LO, 8'h1F);
        bus(1'b1, dtc_pkg::ADDR_CNT0_HI, 8'h00);
        bus(1'b1, dtc_pkg::ADDR_TCS, 8'h10);
        repeat (13) @(posedge sys_clk);
        bus(1'b1, dtc_pkg::ADDR_TCS, 8'h00);
        rchk(dtc_pkg::ADDR_CNT0_HI, 8'h01);
    endtask : t_mode13

    task automatic t_counter();
        bus(1'b1, dtc_pkg::ADDR_TMC, 8'h0D);
        bus(1'b1, dtc_pkg::ADDR_CNT0_LO, 8'h00);
        bus(1'b1, dtc_pkg::ADDR_TCS, 8'h10);
        pulse(3);
        pin0_n <= 1'b0;
        pulse(2);
        pin0_n <= 1'b1;
        bus(1'b1, dtc_pkg::ADDR_TCS, 8'h00);
        rchk(dtc_pkg::ADDR_CNT0_LO, 8'h03);
    endtask : t_counter

    task automatic t_ext();
        bus(1'b1, dtc_pkg::ADDR_IRQ_EN, 8'h85);
        bus(1'b1, dtc_pkg::ADDR_TCS, 8'h01);
        pin0_n <= 1'b0;
        wait_irq(2, 1'b1);
        wait_irq(2, 1'b0);
        pin0_n <= 1'b1;
        pin1_n <= 1'b0;
        wait_irq(3, 1'b1);
        repeat (6) @(posedge sys_clk);
        chk({7'h0, irq[3]}, 8'h01);
        pin1_n <= 1'b1;
        wait_irq(3, 1'b0);
    endtask : t_ext

    // Timer zero split in two: only its high byte runs, off timer one's
    // run bit, while timer one sits halted in mode three.
    task automatic t_split();
        bus(1'b1, dtc_pkg::ADDR_TMC, 8'h33);
        bus(1'b1, dtc_pkg::ADDR_CNT0_HI, 8'hFE);
        bus(1'b1, dtc_pkg::ADDR_CNT0_LO, 8'hFE);
        bus(1'b1, dtc_pkg::ADDR_CNT1_LO, 8'h55);
        bus(1'b1, dtc_pkg::ADDR_IRQ_EN, 8'h8A);
        bus(1'b1, dtc_pkg::ADDR_TCS, 8'h40);
        wait_irq(1, 1'b1);
        rchk(dtc_pkg::ADDR_CNT1_LO, 8'h55);
        rchk(dtc_pkg::ADDR_CNT0_LO, 8'hFE);
        chk({7'h0, irq[0]}, 8'h00);
        bus(1'b1, dtc_pkg::ADDR_TCS, 8'h00);
    endtask : t_split

    // A hang anywhere ends the run as a failure.
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            num_errors++;
            finish_test();
        end
    end

    initial
    begin
        repeat (6) @(posedge sys_clk);
        nrst <= 1'b1;
        t_reset();
        t_mode16();
        t_reload();
        t_mode13();
        t_counter();
        t_ext();
        t_split();
        finish_test();
    end
endmodule : dual_timer_counter_control_bench

// *** logic/dtc_pkg.sv ***
package dtc_pkg;

    // Register indices; the byte address is four times the index.
    localparam logic [7:0] IDX_TCS = 8'h88;
    localparam logic [7:0] IDX_TMC = 8'h89;
    localparam logic [7:0] IDX_CNT0_LO = 8'h8A;
    localparam logic [7:0] IDX_CNT1_LO = 8'h8B;
    localparam logic [7:0] IDX_CNT0_HI = 8'h8C;
    localparam logic [7:0] IDX_CNT1_HI = 8'h8D;
    localparam logic [7:0] IDX_IRQ_EN = 8'h8E;
    localparam int ADDR_W = 12;
    localparam logic [11:0] ADDR_TCS = {2'h0, IDX_TCS, 2'h0};
    localparam logic [11:0] ADDR_TMC = {2'h0, IDX_TMC, 2'h0};
    localparam logic [11:0] ADDR_CNT0_LO = {2'h0, IDX_CNT0_LO, 2'h0};
    localparam logic [11:0] ADDR_CNT1_LO = {2'h0, IDX_CNT1_LO, 2'h0};
    localparam logic [11:0] ADDR_CNT0_HI = {2'h0, IDX_CNT0_HI, 2'h0};
    localparam logic [11:0] ADDR_CNT1_HI = {2'h0, IDX_CNT1_HI, 2'h0};
    localparam logic [11:0] ADDR_IRQ_EN = {2'h0, IDX_IRQ_EN, 2'h0};

    // Fields of timer_control_status.
    localparam int TCS_TF1 = 7;
    localparam int TCS_TR1 = 6;
    localparam int TCS_TF0 = 5;
    localparam int TCS_TR0 = 4;
    localparam int TCS_IE1 = 3;
    localparam int TCS_IT1 = 2;
    localparam int TCS_IE0 = 1;
    localparam int TCS_IT0 = 0;

    // Fields of timer_mode_config.
    localparam int TMC_PIN_GATE_EN1 = 7;
    localparam int TMC_CSEL1 = 6;
    localparam int TMC_MODE1_HI = 5;
    localparam int TMC_MODE1_LO = 4;
    localparam int TMC_PIN_GATE_EN0 = 3;
    localparam int TMC_CSEL0 = 2;
    localparam int TMC_MODE0_HI = 1;
    localparam int TMC_MODE0_LO = 0;

    // Fields of irq_enable_reg_a.
    localparam int IEN_GLOBAL = 7;
    localparam int IEN_TMR1 = 3;
    localparam int IEN_EXT1 = 2;
    localparam int IEN_TMR0 = 1;
    localparam int IEN_EXT0 = 0;

    localparam logic [7:0] TCS_RESET = 8'h00;
    localparam logic [7:0] TMC_RESET = 8'h00;
    localparam logic [7:0] IEN_RESET = 8'h00;
    localparam logic [7:0] CNT_RESET = 8'h00;

    // System clock cycles per timer tick.
    localparam int TICK_DIV = 12;

    typedef enum logic [1:0] {
        DTC_M13 = 2'b00,
        DTC_M16 = 2'b01,
        DTC_M8R = 2'b10,
        DTC_MSPLIT = 2'b11
    } dtc_mode_e;

endpackage : dtc_pkg

// *** logic/dtc_timer_ctrl.sv ***
// Notes on behaviour
// - Overflow of a timer's count sets that timer's overflow flag.
// - Vectoring to a timer's interrupt clears its overflow flag.
// - Timer interrupt request needs that timer's own enable bit.
// - Timer interrupt request also needs the global enable bit.
// - Run bit cleared stops the timer; set lets it run.
// - Gating off: timer counts whenever its run bit is set.
// - Gating on: counts only while its interrupt pin is high and run set.
// - Source select cleared: count the divided system clock.
// - Source select set: count falling edges on the count pin.
// - Mode one makes a full sixteen-bit timer.
// - Mode two: eight-bit low byte reloaded from high byte on overflow.
// - External interrupt detected on its pin sets its flag.
// - Servicing clears an external flag only when edge-triggered.
// - Type bit cleared selects low level; set selects falling edge.
// - Control and mode registers reset to zero.
// - Mode zero: five-bit prescaler in low byte feeds high byte.
// - Auto-reload leaves the high byte unchanged.
// - Timer one in mode three halts and holds its count.
// - Timer zero in mode three takes timer one's flag and run bit.
module dtc_timer_ctrl (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Device pins
    input wire logic ext_irq_pin0_n,
    input wire logic ext_irq_pin1_n,
    input wire logic count_input_pin0,
    input wire logic count_input_pin1,
    // Processor core interrupt interface
    input wire logic vec_ack_tmr0,
    input wire logic vec_ack_tmr1,
    input wire logic vec_ack_ext0,
    input wire logic vec_ack_ext1,
    output logic irq_req_tmr0,
    output logic irq_req_tmr1,
    output logic irq_req_ext0,
    output logic irq_req_ext1
);
    typedef enum logic [1:0] {
        DTC_BUS_IDLE = 2'b00,
        DTC_BUS_WR = 2'b01,
        DTC_BUS_RD = 2'b11,
        DTC_BUS_RDY = 2'b10
    } dtc_bus_e;

    dtc_bus_e bus_q;
    dtc_bus_e bus_d;
    logic [11:0] dph_addr_q;
    logic dph_ok_q;
    logic [31:0] hrdata_q;
    logic [7:0] tcs_q;
    logic [7:0] tcs_d;
    logic [7:0] tmc_q;
    logic [7:0] ien_q;
    logic [3:0] div_cnt_q;
    logic [3:0] pin_prev_q;
    logic tick;
    logic aph_take;
    logic wr_en;
    logic [7:0] wbyte;
    logic [7:0] rd_mux;
    logic fall_ext0;
    logic fall_ext1;
    logic fall_cnt0;
    logic fall_cnt1;
    logic split;
    logic run0;
    logic run1;
    logic src0;
    logic src1;
    logic ovf0;
    logic ovf1;
    dtc_pkg::dtc_mode_e mode0;
    dtc_pkg::dtc_mode_e mode1;

    dtc_tmr_if tmr0_if ();
    dtc_tmr_if tmr1_if ();

    dtc_tmr_unit u_tmr0 (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .t(tmr0_if)
    );

    dtc_tmr_unit u_tmr1 (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .t(tmr1_if)
    );

    // Bus slave. Reads take one wait state so that read data come from a
    // flop and always reflect a write finished in the cycle before.
    assign aph_take = hsel && htrans[1] && hready;
    assign hreadyout = (bus_q != DTC_BUS_RD);
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;
    assign wr_en = (bus_q == DTC_BUS_WR) && dph_ok_q;
    assign wbyte = hwdata[7:0];

    always_comb
    begin
        bus_d = DTC_BUS_IDLE;
        if (bus_q == DTC_BUS_RD)
        begin
            bus_d = DTC_BUS_RDY;
        end
        else if (aph_take)
        begin
            bus_d = hwrite ? DTC_BUS_WR : DTC_BUS_RD;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            bus_q <= DTC_BUS_IDLE;
            dph_addr_q <= 12'h000;
            dph_ok_q <= 1'b0;
        end
        else
        begin
            bus_q <= bus_d;
            if (aph_take && bus_q != DTC_BUS_RD)
            begin
                dph_addr_q <= haddr[11:0];
                dph_ok_q <= (haddr[31:12] == 20'h00000);
            end
        end
    end

    always_comb
    begin
        rd_mux = 8'h00;
        if (dph_ok_q)
        begin
            unique case (dph_addr_q)
                dtc_pkg::ADDR_TCS: rd_mux = tcs_q;
                dtc_pkg::ADDR_TMC: rd_mux = tmc_q;
                dtc_pkg::ADDR_CNT0_LO: rd_mux = tmr0_if.lo;
                dtc_pkg::ADDR_CNT1_LO: rd_mux = tmr1_if.lo;
                dtc_pkg::ADDR_CNT0_HI: rd_mux = tmr0_if.hi;
                dtc_pkg::ADDR_CNT1_HI: rd_mux = tmr1_if.hi;
                dtc_pkg::ADDR_IRQ_EN: rd_mux = ien_q;
                default: rd_mux = 8'h00;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            hrdata_q <= 32'h00000000;
        end
        else if (bus_q == DTC_BUS_RD)
        begin
            hrdata_q <= {24'h000000, rd_mux};
        end
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            tmc_q <= dtc_pkg::TMC_RESET;
            ien_q <= dtc_pkg::IEN_RESET;
        end
        else if (wr_en)
        begin
            if (dph_addr_q == dtc_pkg::ADDR_TMC)
            begin
                tmc_q <= wbyte;
            end
            if (dph_addr_q == dtc_pkg::ADDR_IRQ_EN)
            begin
                ien_q <= wbyte;
            end
        end
    end

    // Tick divider and pin history; pins are synchronous to sys_clk.
    assign tick = (div_cnt_q == 4'(dtc_pkg::TICK_DIV - 1));

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            div_cnt_q <= 4'h0;
        end
        else
        begin
            div_cnt_q <= tick ? 4'h0 : div_cnt_q + 4'h1;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pin_prev_q <= 4'hF;
        end
        else
        begin
            pin_prev_q <= {count_input_pin1, count_input_pin0,
                           ext_irq_pin1_n, ext_irq_pin0_n};
        end
    end

    assign fall_ext0 = pin_prev_q[0] && !ext_irq_pin0_n;
    assign fall_ext1 = pin_prev_q[1] && !ext_irq_pin1_n;
    assign fall_cnt0 = pin_prev_q[2] && !count_input_pin0;
    assign fall_cnt1 = pin_prev_q[3] && !count_input_pin1;

    // Count enables.
    assign mode0 = dtc_pkg::dtc_mode_e'(tmc_q[dtc_pkg::TMC_MODE0_HI:
                                              dtc_pkg::TMC_MODE0_LO]);
    assign mode1 = dtc_pkg::dtc_mode_e'(tmc_q[dtc_pkg::TMC_MODE1_HI:
                                              dtc_pkg::TMC_MODE1_LO]);
    assign split = (mode0 == dtc_pkg::DTC_MSPLIT);
    assign run0 = tcs_q[dtc_pkg::TCS_TR0]
        && (!tmc_q[dtc_pkg::TMC_PIN_GATE_EN0] || ext_irq_pin0_n);
    // With timer zero split, timer one loses its run bit and free-runs;
    // software halts it through mode three instead.
    assign run1 = (split || tcs_q[dtc_pkg::TCS_TR1])
        && (!tmc_q[dtc_pkg::TMC_PIN_GATE_EN1] || ext_irq_pin1_n);
    assign src0 = tmc_q[dtc_pkg::TMC_CSEL0] ? fall_cnt0 : tick;
    assign src1 = tmc_q[dtc_pkg::TMC_CSEL1] ? fall_cnt1 : tick;

    assign tmr0_if.mode = mode0;
    assign tmr0_if.inc_lo = run0 && src0;
    assign tmr0_if.inc_hi = split && tcs_q[dtc_pkg::TCS_TR1] && tick;
    assign tmr0_if.wr_lo = wr_en && dph_addr_q == dtc_pkg::ADDR_CNT0_LO;
    assign tmr0_if.wr_hi = wr_en && dph_addr_q == dtc_pkg::ADDR_CNT0_HI;
    assign tmr0_if.wdata = wbyte;
    assign tmr1_if.mode = mode1;
    assign tmr1_if.inc_lo = run1 && src1
        && (mode1 != dtc_pkg::DTC_MSPLIT);
    assign tmr1_if.inc_hi = 1'b0;
    assign tmr1_if.wr_lo = wr_en && dph_addr_q == dtc_pkg::ADDR_CNT1_LO;
    assign tmr1_if.wr_hi = wr_en && dph_addr_q == dtc_pkg::ADDR_CNT1_HI;
    assign tmr1_if.wdata = wbyte;

    assign ovf0 = tmr0_if.ovf_main;
    assign ovf1 = split ? tmr0_if.ovf_split : tmr1_if.ovf_main;

    // Flags: software write, then hardware clear, then hardware set, so a
    // set in the clearing cycle is never lost.
    always_comb
    begin
        tcs_d = tcs_q;
        if (wr_en && dph_addr_q == dtc_pkg::ADDR_TCS)
        begin
            tcs_d = wbyte;
        end
        if (vec_ack_tmr0)
        begin
            tcs_d[dtc_pkg::TCS_TF0] = 1'b0;
        end
        if (vec_ack_tmr1)
        begin
            tcs_d[dtc_pkg::TCS_TF1] = 1'b0;
        end
        if (vec_ack_ext0 && tcs_q[dtc_pkg::TCS_IT0])
        begin
            tcs_d[dtc_pkg::TCS_IE0] = 1'b0;
        end
        if (vec_ack_ext1 && tcs_q[dtc_pkg::TCS_IT1])
        begin
            tcs_d[dtc_pkg::TCS_IE1] = 1'b0;
        end
        if (ovf0)
        begin
            tcs_d[dtc_pkg::TCS_TF0] = 1'b1;
        end
        if (ovf1)
        begin
            tcs_d[dtc_pkg::TCS_TF1] = 1'b1;
        end
        // In level mode the flag follows the pin, so it stays up for as
        // long as the source holds the line low.
        if (tcs_q[dtc_pkg::TCS_IT0] ? fall_ext0 : 1'b1)
        begin
            tcs_d[dtc_pkg::TCS_IE0] = tcs_q[dtc_pkg::TCS_IT0]
                || !ext_irq_pin0_n;
        end
        if (tcs_q[dtc_pkg::TCS_IT1] ? fall_ext1 : 1'b1)
        begin
            tcs_d[dtc_pkg::TCS_IE1] = tcs_q[dtc_pkg::TCS_IT1]
                || !ext_irq_pin1_n;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            tcs_q <= dtc_pkg::TCS_RESET;
        end
        else
        begin
            tcs_q <= tcs_d;
        end
    end

    assign irq_req_tmr0 = tcs_q[dtc_pkg::TCS_TF0]
        && ien_q[dtc_pkg::IEN_TMR0] && ien_q[dtc_pkg::IEN_GLOBAL];
    assign irq_req_tmr1 = tcs_q[dtc_pkg::TCS_TF1]
        && ien_q[dtc_pkg::IEN_TMR1] && ien_q[dtc_pkg::IEN_GLOBAL];
    assign irq_req_ext0 = tcs_q[dtc_pkg::TCS_IE0]
        && ien_q[dtc_pkg::IEN_EXT0] && ien_q[dtc_pkg::IEN_GLOBAL];
    assign irq_req_ext1 = tcs_q[dtc_pkg::TCS_IE1]
        && ien_q[dtc_pkg::IEN_EXT1] && ien_q[dtc_pkg::IEN_GLOBAL];

    tf_set_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        ovf0 |=> tcs_q[dtc_pkg::TCS_TF0])
        else $error("Timer zero overflow did not set its flag.");

    tf_clear_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        (vec_ack_tmr1 && !ovf1 && !(wr_en && dph_addr_q == dtc_pkg::ADDR_TCS))
        |=> !tcs_q[dtc_pkg::TCS_TF1])
        else $error("Vectoring did not clear timer one flag.");

    irq_enable_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        irq_req_tmr0 |-> ien_q[dtc_pkg::IEN_TMR0] && tcs_q[dtc_pkg::TCS_TF0])
        else $error("Timer zero request without its enable.");

    irq_global_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        !ien_q[dtc_pkg::IEN_GLOBAL] |-> !irq_req_tmr0 && !irq_req_tmr1)
        else $error("Timer request with global enable off.");

    run_stop_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        !tcs_q[dtc_pkg::TCS_TR0] |-> !tmr0_if.inc_lo)
        else $error("Timer zero counted while stopped.");

    ungated_count_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        (tcs_q[dtc_pkg::TCS_TR0] && !tmc_q[dtc_pkg::TMC_PIN_GATE_EN0]
         && !tmc_q[dtc_pkg::TMC_CSEL0] && tick) |-> tmr0_if.inc_lo)
        else $error("Ungated timer zero missed a tick.");

    gated_pin_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        (tmc_q[dtc_pkg::TMC_PIN_GATE_EN0] && !ext_irq_pin0_n) |-> !tmr0_if.inc_lo)
        else $error("Gated timer zero counted with pin low.");

    timer_src_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        (!tmc_q[dtc_pkg::TMC_CSEL0] && tmr0_if.inc_lo) |-> tick)
        else $error("Timer zero counted off the divided clock.");

    counter_src_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        (tmc_q[dtc_pkg::TMC_CSEL0] && tmr0_if.inc_lo)
        |-> $past(count_input_pin0) && !count_input_pin0)
        else $error("Timer zero counted without a falling edge.");

    edge_flag_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        (tcs_q[dtc_pkg::TCS_IT0] && fall_ext0) |=> tcs_q[dtc_pkg::TCS_IE0])
        else $error("Falling edge did not set external flag zero.");

    level_keep_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        (!tcs_q[dtc_pkg::TCS_IT1] && !ext_irq_pin1_n && vec_ack_ext1)
        |=> tcs_q[dtc_pkg::TCS_IE1])
        else $error("Level flag cleared by servicing.");

    halt_hold_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        (mode1 == dtc_pkg::DTC_MSPLIT && !tmr1_if.wr_lo && !tmr1_if.wr_hi)
        |=> $stable(tmr1_if.lo) && $stable(tmr1_if.hi))
        else $error("Timer one moved in mode three.");

    split_flag_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        (split && tmr0_if.ovf_split) |=> tcs_q[dtc_pkg::TCS_TF1])
        else $error("Split high byte overflow did not set timer one flag.");

    read_wait_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        (aph_take && !hwrite && hreadyout) |=> !hreadyout ##1 hreadyout)
        else $error("Read did not take exactly one wait state.");

    ovf_seen_c: cover property (@(posedge sys_clk) disable iff (!nrst)
        ovf0 ##1 irq_req_tmr0);
    reload_seen_c: cover property (@(posedge sys_clk) disable iff (!nrst)
        mode0 == dtc_pkg::DTC_M8R && ovf0);
    split_seen_c: cover property (@(posedge sys_clk) disable iff (!nrst)
        split && tmr0_if.ovf_split);
    ext_edge_c: cover property (@(posedge sys_clk) disable iff (!nrst)
        fall_ext1 && tcs_q[dtc_pkg::TCS_IT1] ##1 vec_ack_ext1);

endmodule : dtc_timer_ctrl

// *** logic/dtc_tmr_if.sv ***
interface dtc_tmr_if;
    dtc_pkg::dtc_mode_e mode;
    logic inc_lo;
    logic inc_hi;
    logic wr_lo;
    logic wr_hi;
    logic [7:0] wdata;
    logic [7:0] lo;
    logic [7:0] hi;
    logic ovf_main;
    logic ovf_split;
    modport ctrl (output mode, inc_lo, inc_hi, wr_lo, wr_hi, wdata,
                  input lo, hi, ovf_main, ovf_split);
    modport unit (input mode, inc_lo, inc_hi, wr_lo, wr_hi, wdata,
                  output lo, hi, ovf_main, ovf_split);
endinterface : dtc_tmr_if

// *** logic/dtc_tmr_unit.sv ***
module dtc_tmr_unit (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Counter control and state
    dtc_tmr_if.unit t
);
    logic [7:0] lo_q;
    logic [7:0] lo_d;
    logic [7:0] hi_q;
    logic [7:0] hi_d;

    always_comb
    begin
        lo_d = lo_q;
        hi_d = hi_q;
        t.ovf_main = 1'b0;
        t.ovf_split = 1'b0;
        if (t.inc_lo)
        begin
            unique case (t.mode)
                dtc_pkg::DTC_M13:
                begin
                    // The upper three bits of the low byte are left alone.
                    lo_d[4:0] = lo_q[4:0] + 5'h01;
                    if (lo_q[4:0] == 5'h1F)
                    begin
                        hi_d = hi_q + 8'h01;
                        t.ovf_main = (hi_q == 8'hFF);
                    end
                end
                dtc_pkg::DTC_M16:
                begin
                    lo_d = lo_q + 8'h01;
                    if (lo_q == 8'hFF)
                    begin
                        hi_d = hi_q + 8'h01;
                        t.ovf_main = (hi_q == 8'hFF);
                    end
                end
                dtc_pkg::DTC_M8R:
                begin
                    if (lo_q == 8'hFF)
                    begin
                        lo_d = hi_q;
                        t.ovf_main = 1'b1;
                    end
                    else
                    begin
                        lo_d = lo_q + 8'h01;
                    end
                end
                dtc_pkg::DTC_MSPLIT:
                begin
                    lo_d = lo_q + 8'h01;
                    t.ovf_main = (lo_q == 8'hFF);
                end
            endcase
        end
        if (t.inc_hi && t.mode == dtc_pkg::DTC_MSPLIT)
        begin
            hi_d = hi_q + 8'h01;
            t.ovf_split = (hi_q == 8'hFF);
        end
        // A software write beats a count in the same cycle.
        if (t.wr_lo)
        begin
            lo_d = t.wdata;
        end
        if (t.wr_hi)
        begin
            hi_d = t.wdata;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            lo_q <= dtc_pkg::CNT_RESET;
            hi_q <= dtc_pkg::CNT_RESET;
        end
        else
        begin
            lo_q <= lo_d;
            hi_q <= hi_d;
        end
    end

    assign t.lo = lo_q;
    assign t.hi = hi_q;

    reload_keep_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        (t.mode == dtc_pkg::DTC_M8R && t.inc_lo && lo_q == 8'hFF
         && !t.wr_lo && !t.wr_hi)
        |=> (lo_q == $past(hi_q) && $stable(hi_q)))
        else $error("Reload did not copy high byte or changed it.");

    prescale_hold_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        (t.mode == dtc_pkg::DTC_M13 && t.inc_lo && lo_q[4:0] != 5'h1F
         && !t.wr_hi && !t.wr_lo)
        |=> ($stable(hi_q) && $stable(lo_q[7:5])))
        else $error("High byte moved before prescaler wrapped.");

    full16_carry_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        (t.mode == dtc_pkg::DTC_M16 && t.inc_lo && lo_q == 8'hFF
         && !t.wr_hi && !t.wr_lo)
        |=> (lo_q == 8'h00 && hi_q == $past(hi_q) + 8'h01))
        else $error("Sixteen-bit carry into high byte missing.");

endmodule : dtc_tmr_unit
